// file: common/eep_regs.vh
// Opcodes, status bit layout, protection bounds and timing for the EEPROM core
`ifndef EEP_REGS_VH
`define EEP_REGS_VH

// Command opcodes
`define EEP_OP_SET_WE      8'h06
`define EEP_OP_CLR_WE      8'h04
`define EEP_OP_STAT_RD     8'h05
`define EEP_OP_STAT_WR     8'h01
`define EEP_OP_MEM_RD      8'h03
`define EEP_OP_MEM_WR      8'h02

// Status register bit positions
`define EEP_SR_PPE         7
`define EEP_SR_IDSEL       6
`define EEP_SR_ZERO        5
`define EEP_SR_IDLOCK      4
`define EEP_SR_BPHI        3
`define EEP_SR_BPLO        2
`define EEP_SR_WEL         1
`define EEP_SR_BUSY        0

// Status reset value; non-volatile bits start cleared in this model
`define EEP_SR_RESET       8'h00

// Block-protect encodings and lower bounds of protected ranges
`define EEP_BP_NONE        2'h0
`define EEP_BP_QUARTER     2'h1
`define EEP_BP_HALF        2'h2
`define EEP_BP_FULL        2'h3
`define EEP_PROT_QTR_BASE  16'hC000
`define EEP_PROT_HALF_BASE 16'h8000

// Geometry
`define EEP_PAGE_BYTES     128
`define EEP_MEM_BYTES      65536
`define EEP_PAGE_LAST      7'h7F

// Timing
`define EEP_CLK_PERIOD_NS  5
`define EEP_WRITE_TIME_NS  5000
`define EEP_WRITE_CYCLES   (`EEP_WRITE_TIME_NS / `EEP_CLK_PERIOD_NS)

`endif

// file: hdl/eep_pin_sync.v
// Three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module eep_pin_sync #(
	parameter RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire ref_clk_in,
	input  wire rst_n_in,
	// Pin and filtered result
	input  wire pin_in,
	output reg  level_out,
	output reg  rise_out,
	output reg  fall_out
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1        <= RESET_VAL;
			s2        <= RESET_VAL;
			s3        <= RESET_VAL;
			level_out <= RESET_VAL;
			rise_out  <= 1'b0;
			fall_out  <= 1'b0;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			// A change counts only once the later two stages agree
			rise_out <= (s2 == s3) & s3 & ~level_out;
			fall_out <= (s2 == s3) & ~s3 & level_out;
			if (s2 == s3) begin
				level_out <= s3;
			end
		end
	end
endmodule // eep_pin_sync
`default_nettype wire

// file: hdl/eep_wr_timer.v
// Self-timed write cycle counter driving the busy state
`timescale 1ns/1ps
`default_nettype none
module eep_wr_timer #(
	parameter CYCLES = 1000
) (
	// Clock and reset
	input  wire ref_clk_in,
	input  wire rst_n_in,
	// Control
	input  wire start_in,
	output reg  busy_out,
	output reg  done_out
);
	localparam [31:0] LAST = CYCLES - 1;
	reg [31:0] cnt;

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt      <= 32'h00000000;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_out) begin
				busy_out <= 1'b1;
				cnt      <= 32'h00000000;
			end else if (busy_out) begin
				if (cnt == LAST) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end else begin
					cnt <= cnt + 32'h00000001;
				end
			end
		end
	end
endmodule // eep_wr_timer
`default_nettype wire

// file: hdl/eep_core.v
// Serial EEPROM command, protection, page buffer and array core
// What this block does
// - Write accepts up to 128 bytes per selection
// - Only in-page address bits increment on writes
// - Page load pointer wraps to page start
// - Completed write cycle clears write-enable latch
// - Id page uses address bits 6..0 only
// - Id writes refused inside protected range, full
// - Id writes refused while id lock set
// - Status write changes bits 7,6,4,3,2 only
// - Pin protect low with enable blocks status
// - Protect falling before select rise aborts status
// - Protect pin ignored when enable bit clear
// - Read data follows last address bit immediately
// - Read address increments, wraps, ends on select
// - Id-page read increments 7-bit byte address
// - Status read allowed anytime, even while busy
// - Hold pauses: output off, input ignored
// - Reset leaves latch clear and standby
// - Write starts only on proper select rise
// - Access commands ignored while write in progress
// - Unknown opcodes ignored, output stays off
// - Six fixed eight-bit opcodes after select falls
// - Status layout: enable,select,0,lock,bp,latch,busy
// - Block-protect codes select protected upper ranges
// - Setting select and lock together changes neither
`include "eep_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module eep_core #(
	parameter WRITE_CYCLES = `EEP_WRITE_CYCLES
) (
	// Clock and reset
	input  wire       ref_clk_in,
	input  wire       rst_n_in,
	// Serial link pins
	input  wire       spi_sck_in,
	input  wire       spi_cs_n_in,
	input  wire       spi_si_in,
	input  wire       spi_hold_n_in,
	input  wire       spi_wp_n_in,
	output reg        spi_so_out,
	output reg        spi_so_oe_out,
	// Status view
	output reg  [7:0] status_out
);
	localparam [3:0] ST_IDLE   = 4'h0;
	localparam [3:0] ST_OPC    = 4'h1;
	localparam [3:0] ST_ADDR   = 4'h2;
	localparam [3:0] ST_WDATA  = 4'h3;
	localparam [3:0] ST_RDATA  = 4'h4;
	localparam [3:0] ST_STAT   = 4'h5;
	localparam [3:0] ST_SRWR   = 4'h6;
	localparam [3:0] ST_CMDEND = 4'h7;
	localparam [3:0] ST_IGNORE = 4'h8;

	// Filtered pins and write timer outputs
	wire sck_rise;
	wire sck_fall;
	wire cs_n_q;
	wire cs_rise;
	wire cs_fall;
	wire si_q;
	wire hold_n_q;
	wire wp_n_q;
	wire wp_fall;
	wire busy;
	wire wr_done;

	eep_pin_sync #(.RESET_VAL(1'b0)) u_sck (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.pin_in     (spi_sck_in),
		.level_out  (),
		.rise_out   (sck_rise),
		.fall_out   (sck_fall)
	);
	eep_pin_sync #(.RESET_VAL(1'b1)) u_cs (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.pin_in     (spi_cs_n_in),
		.level_out  (cs_n_q),
		.rise_out   (cs_rise),
		.fall_out   (cs_fall)
	);
	eep_pin_sync #(.RESET_VAL(1'b0)) u_si (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.pin_in     (spi_si_in),
		.level_out  (si_q),
		.rise_out   (),
		.fall_out   ()
	);
	eep_pin_sync #(.RESET_VAL(1'b1)) u_hold (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.pin_in     (spi_hold_n_in),
		.level_out  (hold_n_q),
		.rise_out   (),
		.fall_out   ()
	);
	eep_pin_sync #(.RESET_VAL(1'b1)) u_wp (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.pin_in     (spi_wp_n_in),
		.level_out  (wp_n_q),
		.rise_out   (),
		.fall_out   (wp_fall)
	);

	// Storage
	reg [7:0]   mem      [0:`EEP_MEM_BYTES-1];
	reg [7:0]   id_mem   [0:`EEP_PAGE_BYTES-1];
	reg [7:0]   page_buf [0:`EEP_PAGE_BYTES-1];
	reg [127:0] page_mask;

	// Serial engine state
	reg [3:0]  state;
	reg [2:0]  bit_cnt;
	reg [6:0]  sh;
	reg [7:0]  op;
	reg [15:0] addr;
	reg        addr_second;
	reg [7:0]  tx;
	reg        driving;
	reg        wp_abort;
	reg        loaded;

	// Status bits
	reg        protect_pin_enable;
	reg        id_page_select;
	reg        id_page_lock;
	reg        block_protect_hi;
	reg        block_protect_lo;
	reg        write_enable_latch;

	// Commit handshake
	reg        commit_go;
	reg        commit_id;
	reg [8:0]  commit_page;
	reg        sr_go;
	reg        commit_active;
	reg [6:0]  commit_idx;

	wire       held = ~hold_n_q;
	wire [7:0] byte_in = {sh, si_q};
	wire [1:0] bp = {block_protect_hi, block_protect_lo};
	wire [7:0] sr_word = {protect_pin_enable, id_page_select, 1'b0,
		id_page_lock, block_protect_hi, block_protect_lo,
		write_enable_latch, busy};
	wire       hw_protect = protect_pin_enable & ~wp_n_q;
	wire       out_state = (state == ST_RDATA) || (state == ST_STAT);

	// Address of the next byte to fetch for reading
	wire [15:0] next_addr = (state == ST_ADDR) ? {addr[7:0], byte_in} :
		id_page_select ? {addr[15:7], addr[6:0] + 7'h01} :
		addr + 16'h0001;
	wire [7:0] fetch = id_page_select ? id_mem[next_addr[6:0]] :
		mem[next_addr];

	function prot_hit;
		input [1:0]  code;
		input [15:0] a;
		begin
			case (code)
				`EEP_BP_QUARTER: prot_hit = (a >= `EEP_PROT_QTR_BASE);
				`EEP_BP_HALF:    prot_hit = (a >= `EEP_PROT_HALF_BASE);
				`EEP_BP_FULL:    prot_hit = 1'b1;
				default:         prot_hit = 1'b0;
			endcase
		end
	endfunction

	// Page write acceptance checks
	wire id_refused = id_page_lock || (bp == `EEP_BP_FULL) ||
		prot_hit(bp, {9'h000, addr[6:0]});
	wire mem_refused = prot_hit(bp, addr);
	wire wr_ok = write_enable_latch && loaded && (bit_cnt == 3'h0) &&
		(id_page_select ? !id_refused : !mem_refused);
	wire sr_ok = write_enable_latch && !hw_protect && !wp_abort;

	eep_wr_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (commit_go | sr_go),
		.busy_out   (busy),
		.done_out   (wr_done)
	);

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state              <= ST_IDLE;
			bit_cnt            <= 3'h0;
			sh                 <= 7'h00;
			op                 <= 8'h00;
			addr               <= 16'h0000;
			addr_second        <= 1'b0;
			tx                 <= 8'h00;
			driving            <= 1'b0;
			wp_abort           <= 1'b0;
			loaded             <= 1'b0;
			page_mask          <= 128'h0;
			protect_pin_enable <= 1'b0;
			id_page_select     <= 1'b0;
			id_page_lock       <= 1'b0;
			block_protect_hi   <= 1'b0;
			block_protect_lo   <= 1'b0;
			write_enable_latch <= 1'b0;
			commit_go          <= 1'b0;
			commit_id          <= 1'b0;
			commit_page        <= 9'h000;
			sr_go              <= 1'b0;
			spi_so_out         <= 1'b0;
			spi_so_oe_out      <= 1'b0;
			status_out         <= `EEP_SR_RESET;
		end else begin
			commit_go  <= 1'b0;
			sr_go      <= 1'b0;
			status_out <= sr_word;
			spi_so_oe_out <= ~cs_n_q & ~held & out_state & driving;
			if (wr_done) begin
				write_enable_latch <= 1'b0;
			end
			if (cs_fall) begin
				state    <= ST_OPC;
				bit_cnt  <= 3'h0;
				driving  <= 1'b0;
				wp_abort <= 1'b0;
				loaded   <= 1'b0;
			end else if (cs_rise) begin
				state         <= ST_IDLE;
				spi_so_oe_out <= 1'b0;
				if (state == ST_CMDEND && bit_cnt == 3'h0) begin
					case (op)
						`EEP_OP_SET_WE: write_enable_latch <= 1'b1;
						`EEP_OP_CLR_WE: write_enable_latch <= 1'b0;
						`EEP_OP_STAT_WR: begin
							if (sr_ok) begin
								// Only the writable bits move
								protect_pin_enable <= tx[`EEP_SR_PPE];
								block_protect_hi <= tx[`EEP_SR_BPHI];
								block_protect_lo <= tx[`EEP_SR_BPLO];
								if (!(tx[`EEP_SR_IDSEL] &&
									tx[`EEP_SR_IDLOCK])) begin
									id_page_select <= tx[`EEP_SR_IDSEL];
									// Lock is one-way
									id_page_lock <= id_page_lock |
										tx[`EEP_SR_IDLOCK];
								end
								sr_go <= 1'b1;
							end
						end
						default: state <= ST_IDLE;
					endcase
				end
				if (state == ST_WDATA && wr_ok) begin
					commit_go   <= 1'b1;
					commit_id   <= id_page_select;
					commit_page <= addr[15:7];
				end
				if (state == ST_WDATA || state == ST_RDATA) begin
					id_page_select <= 1'b0;
				end
			end else if (!cs_n_q && !held) begin
				if (wp_fall && protect_pin_enable) begin
					wp_abort <= 1'b1;
				end
				if (sck_fall && out_state) begin
					// Shift out on falling edges, MSB first
					spi_so_out <= tx[3'h7 - bit_cnt];
					driving    <= 1'b1;
				end
				if (sck_rise) begin
					sh      <= byte_in[6:0];
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7) begin
						case (state)
							ST_OPC: begin
								op <= byte_in;
								addr_second <= 1'b0;
								case (byte_in)
									`EEP_OP_STAT_RD: begin
										state <= ST_STAT;
										tx    <= sr_word;
									end
									`EEP_OP_SET_WE, `EEP_OP_CLR_WE:
										state <= busy ? ST_IGNORE : ST_CMDEND;
									`EEP_OP_STAT_WR:
										state <= busy ? ST_IGNORE : ST_SRWR;
									`EEP_OP_MEM_RD, `EEP_OP_MEM_WR:
										state <= busy ? ST_IGNORE :
											ST_ADDR;
									default: state <= ST_IGNORE;
								endcase
							end
							ST_ADDR: begin
								addr        <= {addr[7:0], byte_in};
								addr_second <= 1'b1;
								if (addr_second) begin
									if (op == `EEP_OP_MEM_RD) begin
										state <= ST_RDATA;
										tx    <= fetch;
									end else begin
										state     <= ST_WDATA;
										page_mask <= 128'h0;
									end
								end
							end
							ST_WDATA: begin
								page_buf[addr[6:0]]  <= byte_in;
								page_mask[addr[6:0]] <= 1'b1;
								loaded <= 1'b1;
								// Page bits fixed, in-page wraps
								addr <= {addr[15:7],
									addr[6:0] + 7'h01};
							end
							ST_RDATA: begin
								addr <= next_addr;
								tx   <= fetch;
							end
							ST_STAT: tx <= sr_word;
							ST_SRWR: begin
								tx    <= byte_in;
								state <= ST_CMDEND;
							end
							// Extra clocks spoil a completed command
							ST_CMDEND: state <= ST_IGNORE;
							default: state <= state;
						endcase
					end else if (state == ST_CMDEND) begin
						state <= ST_IGNORE;
					end
				end
			end
		end
	end

	// Commit the loaded page bytes during the self-timed cycle
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			commit_active <= 1'b0;
			commit_idx    <= 7'h00;
		end else begin
			if (commit_go) begin
				commit_active <= 1'b1;
				commit_idx    <= 7'h00;
			end else if (commit_active) begin
				if (page_mask[commit_idx]) begin
					if (commit_id) begin
						id_mem[commit_idx] <= page_buf[commit_idx];
					end else begin
						mem[{commit_page, commit_idx}] <=
							page_buf[commit_idx];
					end
				end
				commit_idx <= commit_idx + 7'h01;
				if (commit_idx == `EEP_PAGE_LAST) begin
					commit_active <= 1'b0;
				end
			end
		end
	end
endmodule // eep_core
`default_nettype wire

// file: sim/eep_core_chk.sv
// Port-level assertion checker for the EEPROM core
`timescale 1ns/1ps
`default_nettype none
module eep_core_chk #(
	parameter WRITE_CYCLES = 1000
) (
	// Clock and reset
	input wire logic       ref_clk_in,
	input wire logic       rst_n_in,
	// Watched pins and outputs
	input wire logic       spi_cs_n_in,
	input wire logic       spi_hold_n_in,
	input wire logic       spi_so_oe_out,
	input wire logic [7:0] status_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [15:0] bcnt;
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			bcnt <= 16'h0000;
		else if (status_out[0])
			bcnt <= bcnt + 16'h0001;
		else
			bcnt <= 16'h0000;
	end
	AST_RESET_STATE: assert property ($rose(rst_n_in) |->
		status_out == 8'h00 && !spi_so_oe_out) else $error("bad reset state");
	AST_CS_IDLE: assert property (spi_cs_n_in [*8] |->
		!spi_so_oe_out) else $error("output driven while deselected");
	AST_HOLD_OFF: assert property (!spi_hold_n_in [*8] |->
		!spi_so_oe_out) else $error("output driven during hold");
	AST_ZERO_BIT: assert property (!status_out[5] &&
		(!status_out[0] || status_out[1])) else $error("bad status layout");
	AST_WEL_END: assert property ($fell(status_out[0]) |->
		##[0:2] !status_out[1]) else $error("latch kept after write");
	AST_BUSY_LEN: assert property ($fell(status_out[0]) |->
		bcnt >= WRITE_CYCLES - 2 && bcnt <= WRITE_CYCLES + 2)
		else $error("write cycle length wrong");
	AST_BUSY_CS: assert property ($rose(status_out[0]) |->
		spi_cs_n_in) else $error("write began while selected");
	AST_WEL_CS: assert property ($rose(status_out[1]) |->
		spi_cs_n_in) else $error("latch set while selected");
	AST_STAT_CS: assert property ($changed(status_out[7:2]) |->
		spi_cs_n_in) else $error("status changed while selected");
	AST_LOCK_KEEP: assert property (status_out[4] |=>
		status_out[4]) else $error("lock bit cleared");
endmodule // eep_core_chk
bind eep_core eep_core_chk #(.WRITE_CYCLES(WRITE_CYCLES)) eep_core_chk_i (
	.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in),
	.spi_cs_n_in(spi_cs_n_in),
	.spi_hold_n_in(spi_hold_n_in),
	.spi_so_oe_out(spi_so_oe_out),
	.status_out(status_out)
);
`default_nettype wire

// file: sim/eep_host.sv
// Host serial controller model for the EEPROM link, mode 0
`timescale 1ns/1ps
`default_nettype none
module eep_host (
	// Link pins
	output logic      sck_out,
	output logic      cs_n_out,
	output logic      si_out,
	output logic      hold_n_out,
	input  wire logic so_in,
	input  wire logic so_oe_in
);
	int   hold_bit = -1;
	logic hold_oe  = 1'b0;
	initial begin
		sck_out    = 1'b0; // Clock stands low between frames
		cs_n_out   = 1'b1;
		si_out     = 1'b0;
		hold_n_out = 1'b1;
	end
	task automatic start;
		cs_n_out = 1'b0;
		#62.5;
	endtask
	task automatic stop;
		#62.5;
		cs_n_out = 1'b1;
		si_out   = ~si_out; // Released line carries no stale bit
		#250;
	endtask
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			if (i == hold_bit) begin
				// Clear of the last clock fall, so that fall still counts
				#31.25;
				hold_n_out = 1'b0;
				// Clock and data keep moving; the paused device must not see them
				repeat (4) begin
					#62.5 sck_out = 1'b1;
					si_out = ~si_out;
					#62.5 sck_out = 1'b0;
				end
				#31.25;
				hold_oe    = so_oe_in;
				hold_n_out = 1'b1;
				#62.5;
			end
			si_out = b[i];
			#62.5;
			// Undriven line reads as the inverse of the last bit
			r[i]    = so_oe_in ? so_in : ~so_in;
			sck_out = 1'b1;
			#62.5;
			sck_out = 1'b0;
		end
	endtask
endmodule // eep_host
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the EEPROM command core
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       ref_clk, rst_n, wp_n, sck, cs_n, si, hold_n, so, so_oe;
	logic       oe_seen, chk21;
	logic [7:0] status, r, s;
	logic [7:0] q[$];
	logic [7:0] d[$];
	int         err_total = 0;
	int         compares  = 0;
	logic [7:0] sw_in[4]  = '{8'h2F, 8'h50, 8'h84, 8'h00};
	logic [7:0] sw_exp[4] = '{8'h0C, 8'h00, 8'h84, 8'h00};

	eep_core #(.WRITE_CYCLES(800)) eep_core_i (
		.ref_clk_in(ref_clk), .rst_n_in(rst_n), .spi_sck_in(sck),
		.spi_cs_n_in(cs_n), .spi_si_in(si), .spi_hold_n_in(hold_n),
		.spi_wp_n_in(wp_n), .spi_so_out(so), .spi_so_oe_out(so_oe),
		.status_out(status));
	eep_host eep_host_i (
		.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
		.so_in(so), .so_oe_in(so_oe));

	always @(posedge ref_clk)
		if (so_oe === 1'b1)
			oe_seen = 1'b1;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic op(input logic [7:0] c);
		eep_host_i.start();
		eep_host_i.xfer(c, r);
		eep_host_i.stop();
	endtask
	task automatic srd(output logic [7:0] v);
		eep_host_i.start();
		eep_host_i.xfer(8'h05, r);
		eep_host_i.xfer(8'h00, v);
		eep_host_i.stop();
	endtask
	task automatic rd(input logic [15:0] a, input int n);
		eep_host_i.start();
		eep_host_i.xfer(8'h03, r);
		eep_host_i.xfer(a[15:8], r);
		eep_host_i.xfer(a[7:0], r);
		q = {};
		repeat (n) begin
			eep_host_i.xfer(8'h00, r);
			q.push_back(r);
		end
		eep_host_i.stop();
	endtask
	task automatic wr(input bit en, input logic [7:0] b[$], input logic eb);
		if (en)
			op(8'h06);
		eep_host_i.start();
		foreach (b[i])
			eep_host_i.xfer(b[i], r);
		eep_host_i.stop();
		chk(status & 8'h01, {7'h00, eb});
		if (eb) begin
			srd(s);
			chk(s & 8'h03, 8'h03);
		end
		if (eb && chk21) begin
			oe_seen = 1'b0;
			rd(16'h0000, 1);
			chk({7'h00, oe_seen}, 8'h00);
		end
		s = 8'h01;
		for (int i = 0; i < 30 && s[0] === 1'b1; i++)
			srd(s);
		chk(s & 8'h01, 8'h00);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		#500000;
		err_total++;
		test_done();
	end
	initial begin
		rst_n   = 1'b0;
		wp_n    = 1'b1;
		oe_seen = 1'b0;
		chk21   = 1'b0;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge ref_clk);
		chk(status, 8'h00);
		chk({7'h00, so_oe}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(1'b1, {8'h01, sw_in[i]}, 1'b1);
			srd(s);
			chk(s, sw_exp[i]);
		end
		// Full page load from offset one wraps to the page start
		d = {8'h02, 8'h00, 8'h01};
		for (int i = 0; i < 128; i++)
			d.push_back(i[7:0]);
		chk21 = 1'b1;
		wr(1'b1, d, 1'b1);
		chk21 = 1'b0;
		chk(status, 8'h00);
		rd(16'hFFFF, 3);
		chk(q[1], 8'h7F);
		chk(q[2], 8'h00);
		rd(16'h007F, 1);
		chk(q[0], 8'h7E);
		wr(1'b0, {8'h02, 8'h00, 8'h10, 8'h55}, 1'b0);
		op(8'h06);
		chk(status, 8'h02);
		op(8'h04);
		chk(status, 8'h00);
		wr(1'b1, {8'h01, 8'h04}, 1'b1);
		wr(1'b1, {8'h02, 8'hC0, 8'h00, 8'h11}, 1'b0);
		wr(1'b1, {8'h02, 8'hBF, 8'hFF, 8'h22}, 1'b1);
		wr(1'b1, {8'h01, 8'h80}, 1'b1);
		@(negedge ref_clk) wp_n = 1'b0;
		wr(1'b1, {8'h01, 8'h8C}, 1'b0);
		chk(status, 8'h82);
		@(negedge ref_clk) wp_n = 1'b1;
		eep_host_i.start();
		eep_host_i.xfer(8'h01, r);
		eep_host_i.xfer(8'h0C, r);
		// Pin is back high at select rise, so only the abort can refuse
		@(negedge ref_clk) wp_n = 1'b0;
		repeat (20) @(negedge ref_clk);
		wp_n = 1'b1;
		repeat (20) @(negedge ref_clk);
		eep_host_i.stop();
		chk(status, 8'h82);
		@(negedge ref_clk) wp_n = 1'b1;
		wr(1'b1, {8'h01, 8'h00}, 1'b1);
		@(negedge ref_clk) wp_n = 1'b0;
		wr(1'b1, {8'h01, 8'h0C}, 1'b1);
		wr(1'b1, {8'h01, 8'h00}, 1'b1);
		@(negedge ref_clk) wp_n = 1'b1;
		oe_seen = 1'b0;
		eep_host_i.start();
		eep_host_i.xfer(8'hFF, r);
		eep_host_i.xfer(8'h00, r);
		eep_host_i.stop();
		chk({7'h00, oe_seen}, 8'h00);
		op(8'h06);
		eep_host_i.hold_bit = 3;
		srd(s);
		eep_host_i.hold_bit = -1;
		chk(s, 8'h02);
		chk({7'h00, eep_host_i.hold_oe}, 8'h00);
		// Identification page: select, write, read back, then refusals
		wr(1'b1, {8'h01, 8'h40}, 1'b1);
		wr(1'b1, {8'h02, 8'hFF, 8'h05, 8'h77}, 1'b1);
		wr(1'b1, {8'h01, 8'h40}, 1'b1);
		rd(16'h0005, 1);
		chk(q[0], 8'h77);
		rd(16'h0005, 1);
		chk(q[0], 8'h04);
		wr(1'b1, {8'h01, 8'h4C}, 1'b1);
		wr(1'b1, {8'h02, 8'h00, 8'h06, 8'h33}, 1'b0);
		wr(1'b1, {8'h01, 8'h10}, 1'b1);
		wr(1'b1, {8'h01, 8'h40}, 1'b1);
		wr(1'b1, {8'h02, 8'h00, 8'h05, 8'h11}, 1'b0);
		test_done();
	end
endmodule // testbench
`default_nettype wire
